// >>> fcls_pkg.sv
package fcls_pkg;

   // ******************************************************
   // register map, word addresses on the plain port
   // ******************************************************
   localparam int           ADDR_W         = 4;
   localparam int           DATA_W         = 16;
   localparam logic [3:0]   ADDR_CLKDIV    = 4'h0;
   localparam logic [3:0]   ADDR_INDEX     = 4'h1;
   localparam logic [3:0]   ADDR_STATUS    = 4'h2;
   localparam logic [3:0]   ADDR_PROTECT   = 4'h3;
   localparam logic [3:0]   ADDR_DPROTECT  = 4'h4;
   localparam logic [3:0]   ADDR_PARAM     = 4'h5;
   localparam logic [3:0]   ADDR_RESULT    = 4'h6;

   // ******************************************************
   // field positions and reset values
   // ******************************************************
   localparam int           STAT_COMPLETE  = 7;
   localparam int           STAT_ACCESS_ERROR_FLAG    = 5;
   localparam int           STAT_PROTVIOL  = 4;
   localparam int           DIV_LOADED_BIT = 7;
   localparam int           DIV_W          = 7;
   localparam int           PROT_LOW_DIS   = 2;
   localparam int           PROT_HIGH_DIS  = 1;
   localparam int           PROT_OPEN      = 0;
   localparam int           DPROT_OPEN     = 0;
   localparam int           IDX_W          = 3;
   localparam int           PARAM_WORDS    = 6;
   localparam logic [15:0]  ZERO_WORD      = 16'h0000;
   localparam logic [7:0]   PROT_RESET     = 8'h00;
   localparam logic [6:0]   PFLASH_BLK_HI  = 7'h7F;

   // ******************************************************
   // once-programmable field: 64 bytes as 8 rows of 4 words
   // ******************************************************
   localparam int           ONCE_ROWS      = 8;
   localparam int           ONCE_WORDS     = 32;

   // ******************************************************
   // command codes
   // ******************************************************
   localparam logic [7:0]   CMD_VERIFY_ALL = 8'h01;
   localparam logic [7:0]   CMD_VERIFY_BLK = 8'h02;
   localparam logic [7:0]   CMD_VERIFY_PSEC = 8'h03;
   localparam logic [7:0]   CMD_READ_ONCE  = 8'h04;
   localparam logic [7:0]   CMD_PROG_P     = 8'h06;
   localparam logic [7:0]   CMD_PROG_ONCE  = 8'h07;
   localparam logic [7:0]   CMD_ERASE_ALL  = 8'h08;
   localparam logic [7:0]   CMD_ERASE_BLK  = 8'h09;
   localparam logic [7:0]   CMD_ERASE_PSEC = 8'h0A;
   localparam logic [7:0]   CMD_UNSECURE   = 8'h0B;
   localparam logic [7:0]   CMD_KEY_CHECK  = 8'h0C;
   localparam logic [7:0]   CMD_USER_MARGIN = 8'h0D;
   localparam logic [7:0]   CMD_FIELD_MARGIN = 8'h0E;
   localparam logic [7:0]   CMD_VERIFY_DSEC = 8'h10;
   localparam logic [7:0]   CMD_PROG_D     = 8'h11;
   localparam logic [7:0]   CMD_ERASE_DSEC = 8'h12;

   // ******************************************************
   // operating modes
   // ******************************************************
   localparam logic [1:0]   MODE_NS        = 2'h0;
   localparam logic [1:0]   MODE_NX        = 2'h1;
   localparam logic [1:0]   MODE_SS        = 2'h2;
   localparam logic [1:0]   MODE_ST        = 2'h3;

   // ******************************************************
   // timing
   // ******************************************************
   localparam int           CLK_PERIOD_PS  = 25000;
   localparam int           VERIFY_TIME_NS = 500;
   localparam int           PROG_TIME_NS   = 1000;
   localparam int           ERASE_TIME_NS  = 5000;
   localparam int           CNT_W          = 8;
   localparam logic [7:0]   VERIFY_CYCLES  =
      8'((VERIFY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0]   PROG_CYCLES    =
      8'((PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0]   ERASE_CYCLES   =
      8'((ERASE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [7:0]   SHORT_CYCLES   = 8'h01;

   typedef enum logic [2:0]
   {
      ST_IDLE   = 3'b001,
      ST_RUN    = 3'b010,
      ST_FINISH = 3'b100
   } fcls_state_type;

endpackage

// >>> fcls_sequencer.sv
// Function
// - only mode-valid codes, launched by full sequence
// - busy: refuse launch, ignore parameter writes
// - parameters loaded per word through index
// - write one clears complete flag, launches
// - complete flag low while command runs
// - on finish flag returns high, results out
// - codes 01 02 03 erase verify
// - code 04 reads once field row
// - code 06 programs one phrase
// - code 07 programs one once field row, once per row
// - code 08 erase all needs protect opens
// - code 09 block erase, full needs opens
// - code 0A erases program sector
// - code 0B erases, verifies, then unsecures
// - code 0C key compare, normal single-chip
// - code 0D sets user margin level
// - code 0E field margin, special modes only
// - data flash codes 10 11 12 accepted
// - invalid code sets access error
// - no divider write blocks program and erase
// - word 0 holds code high, address low
`timescale 1ns/1ps

module fcls_sequencer
   import fcls_pkg::*;
(
   input  wire logic                ref_clk,       // bus clock
   input  wire logic                rst,           // sync reset
   input  wire logic [ADDR_W-1:0]   regAddr,       // register address
   input  wire logic [DATA_W-1:0]   regWrData,     // write data
   input  wire logic                regWrite,      // write strobe
   input  wire logic                regRead,       // read strobe
   output logic      [DATA_W-1:0]   regRdData,     // read data, next cycle
   input  wire logic                chipSecured,   // security state
   input  wire logic [1:0]          opMode,        // operating mode
   input  wire logic [63:0]         backdoorKey,   // stored security key
   output logic                     cmdComplete,   // complete flag
   output logic      [7:0]          activeCmd,     // code being run
   output logic                     unsecureGrant, // security released
   output logic      [7:0]          userMargin,    // user margin level
   output logic      [7:0]          fieldMargin    // field margin level
);

   // ******************************************************
   // decode functions
   // ******************************************************
   function automatic logic cmdAllowed(input logic [7:0] code,
                                       input logic [1:0] mode,
                                       input logic       secured);
      logic special;
      logic nsc;
      special = (mode == MODE_SS) || (mode == MODE_ST);
      nsc     = (mode == MODE_NS);
      unique case (code)
         CMD_VERIFY_ALL, CMD_VERIFY_BLK:
            cmdAllowed = 1'b1;
         CMD_VERIFY_PSEC, CMD_READ_ONCE, CMD_PROG_P, CMD_PROG_ONCE,
         CMD_ERASE_BLK, CMD_USER_MARGIN, CMD_VERIFY_DSEC, CMD_PROG_D,
         CMD_ERASE_DSEC:
            cmdAllowed = !secured || nsc;
         CMD_ERASE_ALL, CMD_UNSECURE:
            cmdAllowed = special;
         CMD_ERASE_PSEC:
            cmdAllowed = secured ? nsc : !nsc;
         CMD_KEY_CHECK:
            cmdAllowed = nsc;
         CMD_FIELD_MARGIN:
            cmdAllowed = !secured && special;
         default:
            cmdAllowed = 1'b0;
      endcase
   endfunction

   function automatic logic isProgErase(input logic [7:0] code);
      unique case (code)
         CMD_PROG_P, CMD_PROG_ONCE, CMD_ERASE_ALL, CMD_ERASE_BLK,
         CMD_ERASE_PSEC, CMD_UNSECURE, CMD_PROG_D, CMD_ERASE_DSEC:
            isProgErase = 1'b1;
         default:
            isProgErase = 1'b0;
      endcase
   endfunction

   function automatic logic [CNT_W-1:0] opCycles(input logic [7:0] code);
      unique case (code)
         CMD_ERASE_ALL, CMD_ERASE_BLK, CMD_ERASE_PSEC, CMD_UNSECURE,
         CMD_ERASE_DSEC:
            opCycles = ERASE_CYCLES;
         CMD_PROG_P, CMD_PROG_ONCE, CMD_PROG_D:
            opCycles = PROG_CYCLES;
         CMD_VERIFY_ALL, CMD_VERIFY_BLK, CMD_VERIFY_PSEC, CMD_VERIFY_DSEC:
            opCycles = VERIFY_CYCLES;
         default:
            opCycles = SHORT_CYCLES;
      endcase
   endfunction

   // ******************************************************
   // state
   // ******************************************************
   fcls_state_type            state_reg;
   fcls_state_type            state_next;
   logic                      complete_reg;
   logic                      access_error_flag_reg;
   logic                      protViol_reg;
   logic                      divLoaded_reg;
   logic [DIV_W-1:0]          clkDiv_reg;
   logic [IDX_W-1:0]          index_reg;
   logic [7:0]                protect_reg;
   logic [7:0]                dProtect_reg;
   logic [15:0]               param_reg [PARAM_WORDS];
   logic [15:0]               once_reg  [ONCE_WORDS];
   logic [ONCE_ROWS-1:0]      onceDone_reg;
   logic [7:0]                cmd_reg;
   logic [CNT_W-1:0]          count_reg;
   logic [DATA_W-1:0]         rdData_reg;
   logic                      unsecure_reg;
   logic [7:0]                userMargin_reg;
   logic [7:0]                fieldMargin_reg;
   logic                      keyFail_reg;

   // ******************************************************
   // launch decode
   // ******************************************************
   logic                      statusWrite;
   logic                      launchReq;
   logic [7:0]                newCmd;
   logic [6:0]                newBlock;
   logic [2:0]                newRow;
   logic                      errCode;
   logic                      errDiv;
   logic                      errOnce;
   logic                      errProt;
   logic                      startOp;
   logic                      paramWrite;
   logic                      progOpen;
   logic                      keyMatch;

   assign statusWrite = regWrite && (regAddr == ADDR_STATUS);
   // flags are tested before this write's clear takes effect
   assign launchReq   = statusWrite && regWrData[STAT_COMPLETE]
                        && complete_reg && !access_error_flag_reg
                        && !protViol_reg;
   assign newCmd      = param_reg[0][15:8];
   assign newBlock    = param_reg[0][6:0];
   assign newRow      = param_reg[1][2:0];
   assign errCode     = !cmdAllowed(newCmd, opMode,
                                    chipSecured);
   assign errDiv      = isProgErase(newCmd) && !divLoaded_reg;
   assign errOnce     = (newCmd == CMD_PROG_ONCE)
                        && onceDone_reg[newRow];
   assign progOpen    = protect_reg[PROT_LOW_DIS] && protect_reg[PROT_OPEN]
                        && protect_reg[PROT_HIGH_DIS];

   always_comb
   begin
      errProt = 1'b0;
      if (newCmd == CMD_ERASE_ALL)
      begin
         errProt = !(progOpen && dProtect_reg[DPROT_OPEN]);
      end
      else if (newCmd == CMD_ERASE_BLK)
      begin
         if (newBlock == PFLASH_BLK_HI)
         begin
            errProt = !progOpen;
         end
         else
         begin
            errProt = !dProtect_reg[DPROT_OPEN];
         end
      end
   end

   assign startOp    = launchReq && !errCode && !errDiv && !errOnce
                       && !errProt;
   assign paramWrite = regWrite && (regAddr == ADDR_PARAM)
                       && complete_reg;
   assign keyMatch   = {param_reg[1], param_reg[2], param_reg[3],
                        param_reg[4]} == backdoorKey;

   // ******************************************************
   // sequencer
   // ******************************************************
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE:
            if (startOp)
            begin
               state_next = ST_RUN;
            end
         ST_RUN:
            if (count_reg == SHORT_CYCLES)
            begin
               state_next = ST_FINISH;
            end
         ST_FINISH:
            state_next = ST_IDLE;
         default:
            state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_reg <= ST_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         count_reg <= SHORT_CYCLES;
         cmd_reg   <= 8'h00;
      end
      else if (startOp)
      begin
         count_reg <= opCycles(newCmd);
         cmd_reg   <= newCmd;
      end
      else if (state_reg == ST_RUN)
      begin
         count_reg <= count_reg - SHORT_CYCLES;
      end
   end

   // ******************************************************
   // status flags
   // ******************************************************
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         complete_reg <= 1'b1;
      end
      else if (startOp)
      begin
         complete_reg <= 1'b0;
      end
      else if (state_reg == ST_FINISH)
      begin
         complete_reg <= 1'b1;
      end
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         access_error_flag_reg   <= 1'b0;
         protViol_reg <= 1'b0;
      end
      else
      begin
         access_error_flag_reg   <= (access_error_flag_reg
                          && !(statusWrite && regWrData[STAT_ACCESS_ERROR_FLAG]))
                         || (launchReq && (errCode || errDiv || errOnce))
                         || keyFail_reg;
         protViol_reg <= (protViol_reg
                          && !(statusWrite && regWrData[STAT_PROTVIOL]))
                         || (launchReq && !errCode && !errDiv && !errOnce
                             && errProt);
      end
   end

   // ******************************************************
   // configuration registers
   // ******************************************************
   // divider is only a load marker here; the time base is elsewhere
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         divLoaded_reg <= 1'b0;
         clkDiv_reg    <= '0;
      end
      else if (regWrite && (regAddr == ADDR_CLKDIV) && complete_reg)
      begin
         divLoaded_reg <= 1'b1;
         clkDiv_reg    <= regWrData[DIV_W-1:0];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         index_reg    <= '0;
         protect_reg  <= PROT_RESET;
         dProtect_reg <= PROT_RESET;
      end
      else if (regWrite && complete_reg)
      begin
         if (regAddr == ADDR_INDEX)
         begin
            index_reg <= regWrData[IDX_W-1:0];
         end
         if (regAddr == ADDR_PROTECT)
         begin
            protect_reg <= regWrData[7:0];
         end
         if (regAddr == ADDR_DPROTECT)
         begin
            dProtect_reg <= regWrData[7:0];
         end
      end
   end

   // ******************************************************
   // parameter array and results
   // ******************************************************
   genvar gi;
   generate
      for (gi = 0; gi < PARAM_WORDS; gi++)
      begin : gParam
         always_ff @(posedge ref_clk)
         begin
            if (rst)
            begin
               param_reg[gi] <= ZERO_WORD;
            end
            else if (paramWrite && (index_reg == IDX_W'(gi)))
            begin
               param_reg[gi] <= regWrData;
            end
            else if ((state_reg == ST_FINISH) && (cmd_reg == CMD_READ_ONCE)
                     && (gi >= 2))
            begin
               param_reg[gi] <= once_reg[{newRow, 2'(gi - 2)}];
            end
         end
      end
   endgenerate

   // once field content has no reset, but the row locks in onceDone_reg clear on reset
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         onceDone_reg <= '0;
      end
      else if ((state_reg == ST_FINISH) && (cmd_reg == CMD_PROG_ONCE))
      begin
         onceDone_reg[newRow] <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if ((state_reg == ST_FINISH) && (cmd_reg == CMD_PROG_ONCE))
      begin
         for (int w = 0; w < 4; w++)
         begin
            once_reg[{newRow, 2'(w)}] <= param_reg[w + 2];
         end
      end
   end

   // ******************************************************
   // command effects
   // ******************************************************
   // array contents are not modelled: verify, program and erase codes
   // run for their time and finish without error
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         unsecure_reg    <= 1'b0;
         keyFail_reg     <= 1'b0;
         userMargin_reg  <= 8'h00;
         fieldMargin_reg <= 8'h00;
      end
      else
      begin
         unsecure_reg <= 1'b0;
         keyFail_reg  <= 1'b0;
         if (state_reg == ST_FINISH)
         begin
            unique case (cmd_reg)
               CMD_UNSECURE:
                  unsecure_reg <= 1'b1;
               CMD_KEY_CHECK:
               begin
                  unsecure_reg <= keyMatch;
                  keyFail_reg  <= !keyMatch;
               end
               CMD_USER_MARGIN:
                  userMargin_reg <= param_reg[1][7:0];
               CMD_FIELD_MARGIN:
                  fieldMargin_reg <= param_reg[1][7:0];
               default:
                  unsecure_reg <= 1'b0;
            endcase
         end
      end
   end

   // ******************************************************
   // read port
   // ******************************************************
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rdData_reg <= ZERO_WORD;
      end
      else if (regRead)
      begin
         unique case (regAddr)
            ADDR_CLKDIV:
               rdData_reg <= {8'h00, divLoaded_reg, clkDiv_reg};
            ADDR_INDEX:
               rdData_reg <= {13'h0000, index_reg};
            ADDR_STATUS:
               rdData_reg <= {8'h00, complete_reg, 1'b0, access_error_flag_reg,
                              protViol_reg, 4'h0};
            ADDR_PROTECT:
               rdData_reg <= {8'h00, protect_reg};
            ADDR_DPROTECT:
               rdData_reg <= {8'h00, dProtect_reg};
            ADDR_PARAM:
               rdData_reg <= (index_reg < IDX_W'(PARAM_WORDS))
                             ? param_reg[index_reg] : ZERO_WORD;
            ADDR_RESULT:
               rdData_reg <= {onceDone_reg, cmd_reg};
            default:
               rdData_reg <= ZERO_WORD;
         endcase
      end
      else
      begin
         rdData_reg <= ZERO_WORD;
      end
   end

   assign regRdData     = rdData_reg;
   assign cmdComplete   = complete_reg;
   assign activeCmd     = cmd_reg;
   assign unsecureGrant = unsecure_reg;
   assign userMargin    = userMargin_reg;
   assign fieldMargin   = fieldMargin_reg;

endmodule

// >>> fcls_sequencer_checker.sv
`timescale 1ns/1ps
// ********
// launch sequencer checks
// ********
module fcls_sequencer_checker
   import fcls_pkg::*;
(
   input wire logic              ref_clk,       // clock
   input wire logic              rst,           // reset
   input wire logic [ADDR_W-1:0] regAddr,       // address
   input wire logic [DATA_W-1:0] regWrData,     // write data
   input wire logic              regWrite,      // write strobe
   input wire logic [1:0]        opMode,        // mode
   input wire logic              cmdComplete,   // idle flag
   input wire logic [7:0]        activeCmd,     // launched code
   input wire logic              unsecureGrant, // release pulse
   input wire logic [7:0]        userMargin,    // user level
   input wire logic [7:0]        fieldMargin    // field level
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   reset_idle_a:
      assert property (disable iff (1'b0) rst |=> cmdComplete)
      else $error("complete flag low after reset");
   busy_min_a:
      assert property ($fell(cmdComplete) |=> !cmdComplete)
      else $error("complete flag back too early");
   // longest run is an erase: 200 cycles plus the finish cycle
   busy_max_a:
      assert property ($fell(cmdComplete) |-> ##[1:201] cmdComplete)
      else $error("complete flag stuck low");
   launch_cause_a:
      assert property ($fell(cmdComplete) |-> $past(regWrite)
         && $past(regAddr) == ADDR_STATUS && $past(regWrData[STAT_COMPLETE]))
      else $error("command started without launch write");
   grant_pulse_a:
      assert property (unsecureGrant |=> !unsecureGrant)
      else $error("release pulse longer than one cycle");
   grant_unsec_a:
      assert property (unsecureGrant && activeCmd == CMD_UNSECURE
         |-> $rose(cmdComplete))
      else $error("release not at end of unsecure");
   unsec_release_a:
      assert property ($rose(cmdComplete) && activeCmd == CMD_UNSECURE
         |-> unsecureGrant)
      else $error("no release at end of unsecure");
   user_margin_a:
      assert property ($changed(userMargin)
         |-> activeCmd == CMD_USER_MARGIN)
      else $error("user level changed by other code");
   field_margin_a:
      assert property ($changed(fieldMargin)
         |-> activeCmd == CMD_FIELD_MARGIN && opMode[1])
      else $error("field level changed outside special mode");
endmodule

// >>> fcls_sequencer_tb_top.sv
`timescale 1ns/1ps
module fcls_sequencer_tb_top
   import fcls_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  regAddr = 4'h0;
   logic [15:0] regWrData = 16'h0000;
   logic [15:0] regRdData;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic        chipSecured = 1'b0;
   logic [1:0]  opMode = 2'h0;
   logic [63:0] backdoorKey = 64'h0;
   logic        cmdComplete;
   logic        unsecureGrant;
   logic [7:0]  activeCmd;
   logic [7:0]  userMargin;
   logic [7:0]  fieldMargin;
   int          fail_count = 0;
   int          n_compared = 0;

   always #12.5 ref_clk = ~ref_clk;

   fcls_sequencer i_fcls_sequencer (.ref_clk, .rst, .regAddr, .regWrData,
      .regWrite, .regRead, .regRdData, .chipSecured, .opMode, .backdoorKey,
      .cmdComplete, .activeCmd, .unsecureGrant, .userMargin, .fieldMargin);

   // ********
   // bus and compare helpers
   // ********
   task automatic chk(input string s, input logic [15:0] e,
      input logic [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask

   task automatic complete_run;
      if (fail_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // strobe drops for a cycle so no signal is driven twice in one step
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] e,
      input string s);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge ref_clk);
      regRead <= 1'b0;
      // data stand only in the cycle after the strobe: look mid-cycle
      @(negedge ref_clk);
      chk(s, e, regRdData);
      @(posedge ref_clk);
   endtask

   // counts busy cycles; sees the value of the cycle before each edge
   task automatic waitdone(output int n);
      n = 0;
      while (cmdComplete !== 1'b1 && n < 300)
      begin
         n++;
         @(posedge ref_clk);
      end
      if (n == 300)
      begin
         fail_count++;
         complete_run();
      end
   endtask

   function automatic int lat(input logic [7:0] c);
      case (c)
         8'h08, 8'h09, 8'h0A, 8'h0B, 8'h12: return 200;
         8'h06, 8'h07, 8'h11: return 40;
         8'h01, 8'h02, 8'h03, 8'h10: return 20;
         default: return 1;
      endcase
   endfunction

   function automatic logic ok(input logic [7:0] c, input logic s,
      input logic [1:0] m);
      case (c)
         8'h01, 8'h02: return 1'b1;
         8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0D, 8'h10, 8'h11, 8'h12:
            return !s || m == 2'h0;
         8'h08, 8'h0B: return m[1];
         8'h0A: return s ? m == 2'h0 : m != 2'h0;
         8'h0C: return m == 2'h0;
         8'h0E: return !s && m[1];
         default: return 1'b0;
      endcase
   endfunction

   task automatic run(input logic [7:0] c, input logic [15:0] w,
      input logic [15:0] st);
      int n;
      for (int i = 0; i < 6; i++)
      begin
         wr(ADDR_INDEX, 16'(i));
         wr(ADDR_PARAM, i == 0 ? {c, 8'h7F} : i == 1 ? w : {c, w[7:0]});
      end
      wr(ADDR_STATUS, 16'h0080);
      waitdone(n);
      chk("busy", st == 16'h0080 ? 16'(lat(c) + 1) : 16'h0000, 16'(n));
      rd(ADDR_STATUS, st, "status");
      if (st == 16'h0080)
         chk("code", {8'h00, c}, {8'h00, activeCmd});
      wr(ADDR_STATUS, 16'h0030);
   endtask

   // ********
   // scenarios
   // ********
   task automatic t_reset;
      chk("idle", 16'h0001, 16'(cmdComplete));
      rd(ADDR_STATUS, 16'h0080, "status");
      rd(ADDR_CLKDIV, 16'h0000, "divider");
      rd(4'hF, 16'h0000, "unmapped");
   endtask

   task automatic t_div;
      run(8'h06, 16'h0000, 16'h00A0);
      wr(ADDR_CLKDIV, 16'h0005);
      rd(ADDR_CLKDIV, 16'h0085, "divider");
   endtask

   task automatic t_prot;
      opMode <= 2'h2;
      run(8'h08, 16'h0000, 16'h0090);
      run(8'h09, 16'h0000, 16'h0090);
      wr(ADDR_PROTECT, 16'h0007);
      run(8'h09, 16'h0000, 16'h0080);
      run(8'h08, 16'h0000, 16'h0090);
      wr(ADDR_DPROTECT, 16'h0001);
      run(8'h08, 16'h0000, 16'h0080);
   endtask

   task automatic t_busy;
      int n;
      wr(ADDR_INDEX, 16'h0000);
      wr(ADDR_PARAM, 16'h127F);
      wr(ADDR_STATUS, 16'h0080);
      wr(ADDR_INDEX, 16'h0001);
      wr(ADDR_PARAM, 16'h5555);
      wr(ADDR_STATUS, 16'h0080);
      waitdone(n);
      // three refused writes took six of the 201 busy cycles
      chk("busy", 16'h00C9, 16'(n + 6));
      rd(ADDR_PARAM, 16'h127F, "param");
      rd(ADDR_STATUS, 16'h0080, "status");
      chk("idle", 16'h0001, 16'(cmdComplete));
   endtask

   task automatic t_modes;
      for (int m = 0; m < 8; m++)
      begin
         chipSecured <= m[2];
         opMode <= 2'(m);
         backdoorKey <= {16'(m), {3{8'h0C, 8'(m)}}};
         for (int c = 0; c < 19; c++)
         begin
            logic [15:0] st;
            st = ok(8'(c), m[2], 2'(m)) ? 16'h0080 : 16'h00A0;
            run(8'(c), 16'(m), st);
            if (c == 13 && st == 16'h0080)
               chk("user", 16'(userMargin), 16'(m));
            if (c == 14 && st == 16'h0080)
               chk("field", 16'(fieldMargin), 16'(m));
         end
      end
   endtask

   task automatic t_once;
      opMode <= 2'h0;
      chipSecured <= 1'b0;
      run(8'h07, 16'h0000, 16'h00A0);
      run(8'h01, 16'h0000, 16'h0080);
      rd(ADDR_RESULT, 16'h1F01, "result");
      run(8'h04, 16'h0003, 16'h0080);
      rd(ADDR_PARAM, 16'h0703, "once");
   endtask

   initial
   begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_div();
      t_prot();
      t_busy();
      t_modes();
      t_once();
      complete_run();
   end
endmodule

bind fcls_sequencer fcls_sequencer_checker i_fcls_sequencer_checker (
   .ref_clk, .rst, .regAddr, .regWrData, .regWrite, .opMode,
   .cmdComplete, .activeCmd, .unsecureGrant, .userMargin, .fieldMargin);
